/* logic/swc_defines.svh */
// offsets, field positions, reset values and timing counts
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH
`define SWC_OFF_CMD 8'h00
`define SWC_OFF_CFG 8'h04
`define SWC_OFF_STAT 8'h08
`define SWC_KEY_MSB 31
`define SWC_KEY_LSB 24
`define SWC_KEY_VALUE 8'hA5
`define SWC_OFF_BIT 0
`define SWC_EDGE_MSB 1
`define SWC_EDGE_LSB 0
`define SWC_DEB_MSB 7
`define SWC_DEB_LSB 4
`define SWC_ALARM_EN_BIT 17
`define SWC_WAKE_FLAG_BIT 0
`define SWC_ALARM_FLAG_BIT 17
`define SWC_CFG_RESET 32'h00000003
`define SWC_CMD_DELAY 2'h2
`define SWC_DEB_UNIT 4
`define SWC_SYNC_LAG 3
`endif

/* logic/swc_pkg.sv */
// types shared by the shutdown and wake-up logic
`default_nettype none
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_EDGE_NONE = 2'h0,
    SWC_EDGE_RISE = 2'h1,
    SWC_EDGE_FALL = 2'h2,
    SWC_EDGE_BOTH = 2'h3
  } swc_edge_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } swc_req_t;
endpackage
`default_nettype wire

/* logic/swc_shutdown_wakeup.sv */
// shutdown output control with debounced wake input and alarm wake
`timescale 1ns/1ps
`default_nettype none
`include "swc_defines.svh"
module swc_shutdown_wakeup #(
  parameter int DEB_W = 4
) (
  // slow clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // register port
  input wire swc_pkg::swc_req_t req_in,
  output logic [31:0] rdata_out,
  // pins
  input wire logic wake_in0,
  input wire logic rtc_alarm_in,
  output logic power_off_out
);
  localparam int CNT_W = DEB_W + `SWC_DEB_UNIT + 1;

  // synchronisers, first stage read only by the second
  logic wk_s1, wk_s2, wk_s3, al_s1, al_s2, al_s3;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wk_s1 <= 1'b0;
      wk_s2 <= 1'b0;
      wk_s3 <= 1'b0;
      al_s1 <= 1'b0;
      al_s2 <= 1'b0;
      al_s3 <= 1'b0;
    end else begin
      wk_s1 <= wake_in0;
      wk_s2 <= wk_s1;
      wk_s3 <= wk_s2;
      al_s1 <= rtc_alarm_in;
      al_s2 <= al_s1;
      al_s3 <= al_s2;
    end
  end

  // state
  logic [1:0] edge_sel, next_edge_sel;
  logic [DEB_W-1:0] deb, next_deb;
  logic alarm_en, next_alarm_en;
  logic wake_flag, next_wake_flag;
  logic alarm_flag, next_alarm_flag;
  logic [1:0] cmd_dly, next_cmd_dly;
  logic off, next_off;
  logic armed, next_armed;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [1:0] fill, next_fill;
  logic [31:0] next_rdata;

  logic rise, fall, chg, hit, key_ok, wake_evt, alarm_evt, stat_rd;
  logic synced;
  logic [CNT_W-1:0] target, head;

  always_comb begin
    // edges blind until every stage holds a real pin level, so a pin
    // idling high shows no false edge after reset
    next_fill = (fill == 2'h3) ? fill : fill + 2'h1;
    synced = fill == 2'h3;
    rise = synced & wk_s2 & ~wk_s3;
    fall = synced & ~wk_s2 & wk_s3;
    chg = rise | fall;
    unique case (swc_pkg::swc_edge_t'(edge_sel))
      swc_pkg::SWC_EDGE_NONE: hit = 1'b0;
      swc_pkg::SWC_EDGE_RISE: hit = rise;
      swc_pkg::SWC_EDGE_FALL: hit = fall;
      swc_pkg::SWC_EDGE_BOTH: hit = chg;
    endcase
    target = CNT_W'({deb, {`SWC_DEB_UNIT{1'b0}}});
    // head start for the synchroniser lag: counting runs from the pin,
    // clamped so a short count still ends exactly on its target
    head = CNT_W'(`SWC_SYNC_LAG);
    if (target < head) begin
      head = target;
    end
    // count at target means held long enough; zero count fires next cycle
    wake_evt = armed && !chg && cnt >= target;
    alarm_evt = synced && alarm_en && al_s2 && !al_s3;
    key_ok = req_in.wdata[`SWC_KEY_MSB:`SWC_KEY_LSB] == `SWC_KEY_VALUE;
    stat_rd = req_in.sel && req_in.rd && req_in.addr == `SWC_OFF_STAT;

    next_edge_sel = edge_sel;
    next_deb = deb;
    next_alarm_en = alarm_en;
    if (req_in.sel && req_in.wr && req_in.addr == `SWC_OFF_CFG) begin
      next_edge_sel = req_in.wdata[`SWC_EDGE_MSB:`SWC_EDGE_LSB];
      next_deb = req_in.wdata[`SWC_DEB_MSB:`SWC_DEB_LSB];
      next_alarm_en = req_in.wdata[`SWC_ALARM_EN_BIT];
    end

    // debounce: a selected edge restarts the count; any other input change before completion cancels it
    next_armed = armed;
    next_cnt = cnt;
    if (hit) begin
      next_armed = 1'b1;
      next_cnt = head;
    end else if (armed && chg) begin
      next_armed = 1'b0;
      next_cnt = '0;
    end else if (wake_evt) begin
      next_armed = 1'b0;
      next_cnt = '0;
    end else if (armed) begin
      next_cnt = cnt + CNT_W'(1);
    end

    // command delay pipe
    next_cmd_dly = cmd_dly;
    if (cmd_dly != 2'h0) begin
      next_cmd_dly = cmd_dly - 2'h1;
    end
    if (req_in.sel && req_in.wr && req_in.addr == `SWC_OFF_CMD
        && key_ok && req_in.wdata[`SWC_OFF_BIT]) begin
      next_cmd_dly = `SWC_CMD_DELAY;
    end

    // wake wins over a command landing in the same cycle
    next_off = off;
    if (cmd_dly == 2'h1) begin
      next_off = 1'b1;
    end
    if (wake_evt || alarm_evt) begin
      next_off = 1'b0;
    end

    // set wins over read-clear
    next_wake_flag = (wake_flag && !stat_rd) || wake_evt;
    next_alarm_flag = (alarm_flag && !stat_rd) || alarm_evt;

    next_rdata = '0;
    if (req_in.sel && req_in.rd) begin
      unique case (req_in.addr)
        `SWC_OFF_CFG: begin
          next_rdata[`SWC_EDGE_MSB:`SWC_EDGE_LSB] = edge_sel;
          next_rdata[`SWC_DEB_MSB:`SWC_DEB_LSB] = deb;
          next_rdata[`SWC_ALARM_EN_BIT] = alarm_en;
        end
        `SWC_OFF_STAT: begin
          next_rdata[`SWC_WAKE_FLAG_BIT] = wake_flag;
          next_rdata[`SWC_ALARM_FLAG_BIT] = alarm_flag;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      edge_sel <= 2'(`SWC_CFG_RESET);
      deb <= '0;
      alarm_en <= 1'b0;
      wake_flag <= 1'b0;
      alarm_flag <= 1'b0;
      cmd_dly <= 2'h0;
      off <= 1'b0;
      armed <= 1'b0;
      cnt <= '0;
      fill <= 2'h0;
      rdata_out <= '0;
    end else begin
      edge_sel <= next_edge_sel;
      deb <= next_deb;
      alarm_en <= next_alarm_en;
      wake_flag <= next_wake_flag;
      alarm_flag <= next_alarm_flag;
      cmd_dly <= next_cmd_dly;
      off <= next_off;
      armed <= next_armed;
      cnt <= next_cnt;
      fill <= next_fill;
      rdata_out <= next_rdata;
    end
  end

  assign power_off_out = off;

  a_cmd_delay: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (req_in.sel && req_in.wr && req_in.addr == `SWC_OFF_CMD && key_ok
     && req_in.wdata[`SWC_OFF_BIT] && !off) ##1 (!wake_evt && !alarm_evt)[*2]
    |=> power_off_out) else $error("off command not applied after delay");
  a_bad_key: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (req_in.sel && req_in.wr && req_in.addr == `SWC_OFF_CMD && !key_ok
     && cmd_dly == 2'h0) |=> cmd_dly == 2'h0)
    else $error("unkeyed command accepted");
  a_zero_cmd: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (req_in.sel && req_in.wr && req_in.addr == `SWC_OFF_CMD
     && !req_in.wdata[`SWC_OFF_BIT] && cmd_dly == 2'h0) |=> cmd_dly == 2'h0)
    else $error("zero command had effect");
  a_hold_off: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    ($fell(power_off_out)) |-> $past(wake_evt || alarm_evt))
    else $error("output released without wake");
  a_wake_release: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (wake_evt && cmd_dly != 2'h1) |=> !power_off_out && wake_flag)
    else $error("wake did not release output");
  a_wake_time: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    wake_evt |-> cnt == target) else $error("wake fired at wrong count");
  a_alarm_gate: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (!alarm_en && !alarm_flag && !stat_rd) |=> !alarm_flag)
    else $error("disabled alarm set flag");
  a_alarm_flag: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (synced && alarm_en && $rose(al_s2)) |=> alarm_flag)
    else $error("alarm edge missed");
  a_flag_clear: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (stat_rd && !wake_evt) |=> !wake_flag)
    else $error("read did not clear flag");
  a_cnt_restart: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    (armed && chg && !hit) |=> cnt == '0 && !armed)
    else $error("counter not cleared on change");
endmodule
`default_nettype wire

/* tb/swc_partner.sv */
// push-button and supply converter seen from the shutdown pins
`timescale 1ns/1ps
`default_nettype none
module swc_partner (
  // bench commands
  input wire logic press_in,
  input wire logic alarm_in,
  // device pins
  input wire logic power_off_in,
  output logic wake_out,
  output logic alarm_out,
  output logic rail_on_out
);
  // button has no bounce here; glitches come from the bench
  assign wake_out = press_in;
  assign alarm_out = alarm_in;
  assign rail_on_out = !power_off_in;
endmodule
`default_nettype wire

/* tb/tb.sv */
// register-level bench for the shutdown and wake-up logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in = 0;
  logic arst_n_in = 0;
  logic press = 0;
  logic alarm = 0;
  swc_pkg::swc_req_t req = '0;
  logic [31:0] rdata_out, rv;
  logic wake, alarm_pin, power_off_out, rail_on;
  int n_mismatch = 0;
  int checks_done = 0;
  initial forever #2 clock_in = ~clock_in;
  swc_shutdown_wakeup swc_shutdown_wakeup_inst (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .req_in(req), .rdata_out(rdata_out),
    .wake_in0(wake), .rtc_alarm_in(alarm_pin),
    .power_off_out(power_off_out));
  swc_partner swc_partner_inst (.press_in(press), .alarm_in(alarm),
    .power_off_in(power_off_out), .wake_out(wake),
    .alarm_out(alarm_pin), .rail_on_out(rail_on));
  task check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock_in) req <= '{1'b1, 1'b1, 1'b0, a, d};
    @(negedge clock_in) req <= '0;
  endtask
  // read data stands only in the cycle after the access edge
  task rd(input logic [7:0] a);
    @(negedge clock_in) req <= '{1'b1, 1'b0, 1'b1, a, 32'h00000000};
    @(negedge clock_in) req <= '0;
    rv = rdata_out;
    @(negedge clock_in);
  endtask
  task idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task off_cmd;
    wr(8'h00, 32'hA5000001);
    idle(3);
  endtask
  // bounded wait for the output to drop
  task released(input string what, input int lim);
    int n;
    n = 0;
    while (power_off_out === 1'b1 && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    check(what, {31'h0, power_off_out}, 32'h0);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    idle(10);
    arst_n_in = 1;
    rd(8'h04);
    check("cfg", rv, 32'h00000003);
    rd(8'h08);
    check("stat", rv, 32'h0);
    rd(8'h0C);
    check("hole", rv, 32'h0);
    wr(8'h00, 32'h5A000001);
    wr(8'h00, 32'hA5000000);
    idle(4);
    check("nokey", {31'h0, power_off_out}, 32'h0);
    wr(8'h04, 32'h00000011);
    wr(8'h00, 32'hA5000001);
    check("cmd0", {31'h0, power_off_out}, 32'h0);
    idle(1);
    check("cmd1", {31'h0, power_off_out}, 32'h0);
    idle(1);
    check("cmd2", {31'h0, power_off_out}, 32'h1);
    check("rail", {31'h0, rail_on}, 32'h0);
    $display("test command done");
    press = 1;
    idle(8);
    press = 0;
    idle(40);
    check("glitch", {31'h0, power_off_out}, 32'h1);
    press = 1;
    idle(16);
    check("early", {31'h0, power_off_out}, 32'h1);
    released("rise", 1);
    rd(8'h08);
    check("flag", rv, 32'h00000001);
    rd(8'h08);
    check("clear", rv, 32'h0);
    $display("test wake done");
    wr(8'h04, 32'h00000010);
    off_cmd();
    press = 0;
    idle(30);
    press = 1;
    idle(30);
    check("none", {31'h0, power_off_out}, 32'h1);
    wr(8'h04, 32'h00000012);
    press = 0;
    idle(16);
    check("early fall", {31'h0, power_off_out}, 32'h1);
    released("fall", 1);
    rd(8'h08);
    check("flag fall", rv, 32'h00000001);
    off_cmd();
    alarm = 1;
    idle(10);
    check("alarm off", {31'h0, power_off_out}, 32'h1);
    alarm = 0;
    wr(8'h04, 32'h00020010);
    rd(8'h04);
    check("cfg rw", rv, 32'h00020010);
    idle(4);
    alarm = 1;
    released("alarm", 8);
    rd(8'h08);
    check("aflag", rv, 32'h00020000);
    $display("test alarm done");
    wr(8'h04, 32'h00000013);
    off_cmd();
    press = 1;
    idle(16);
    check("early both", {31'h0, power_off_out}, 32'h1);
    released("both rise", 1);
    off_cmd();
    press = 0;
    idle(16);
    check("late both", {31'h0, power_off_out}, 32'h1);
    released("both fall", 1);
    rd(8'h08);
    check("both flag", rv, 32'h00000001);
    $display("test both edges done");
    report_and_stop();
  end
endmodule
`default_nettype wire
